// *** common/oss_pkg.sv ***
`default_nettype none
package oss_pkg;
    // command and status word layout
    localparam int CMD_W = 16;
    localparam int OUT_N = 8;
    localparam int OUT_LSB = 0;
    localparam int OLC_LSB = 8;
    localparam int OUT5_IDX = 4;
    localparam int OUT6_IDX = 5;
    localparam logic [CMD_W-1:0] CMD_RST = 16'h0000;
    localparam logic [CMD_W-OUT_N-1:0] STATUS_HI = 8'h00;
    localparam logic [OUT_N-1:0] OUT_OFF = 8'h00;

    // clock pulse counting: 16 first, then steps of 8
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_MIN = 5'h10;
    localparam logic [CNT_W-1:0] CNT_WRAP = 5'h17;

    // synchroniser groups
    localparam int CTL_W = 5;
    localparam int CTL_ARMED = 0;
    localparam int CTL_DD5 = 1;
    localparam int CTL_DD6 = 2;
    localparam int CTL_EN = 3;
    localparam int CTL_CS = 4;
    localparam logic [CTL_W-1:0] CTL_RST = 5'h11;
    localparam int FLT_W = 3 * OUT_N;
    localparam logic [FLT_W-1:0] FLT_RST = 24'h000000;
endpackage : oss_pkg
`default_nettype wire

// *** rtl/oss_sync.sv ***
`default_nettype none
module oss_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    logic [W-1:0] agree;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            q_q <= RST;
        else
            q_q <= (agree & s3_q) | (~agree & q_q);
    end

    assign q = q_q;
endmodule : oss_sync
`default_nettype wire

// *** rtl/oss_switch_ctrl.sv ***
`default_nettype none
module oss_switch_ctrl
    import oss_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_input,
    output logic serial_data_output,
    output logic serial_data_oe,
    input wire logic chip_activate,
    input wire logic direct_drive_five,
    input wire logic direct_drive_six,
    input wire logic [OUT_N-1:0] short_fault,
    input wire logic [OUT_N-1:0] open_load,
    input wire logic [OUT_N-1:0] thermal_limit,
    output logic [OUT_N-1:0] out_on,
    output logic [OUT_N-1:0] olc_en
);
    // serial clock domain
    logic armed_q;
    logic first_q;
    logic sdo_q;
    logic [CMD_W-1:0] shift_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CMD_W-1:0] status_word;

    // system clock domain
    logic [CTL_W-1:0] ctl_s;
    logic [FLT_W-1:0] flt_s;
    logic cs_s;
    logic en_s;
    logic dd5_s;
    logic dd6_s;
    logic armed_s;
    logic cs_prev_q;
    logic en_prev_q;
    logic cs_rise;
    logic en_rise;
    logic clocked_q;
    logic take;
    logic [CMD_W-1:0] cmd_q;
    logic [OUT_N-1:0] out_on_q;
    logic [OUT_N-1:0] olc_en_q;
    logic [OUT_N-1:0] snap_q;
    logic [OUT_N-1:0] fault_vec;
    logic [OUT_N-1:0] dd_vec;
    logic sdo_oe_q;

    // snap_q is frozen while chip select is low, so it is quasi-static here
    assign status_word = {STATUS_HI, snap_q};

    // armed while deselected; cleared by the first rising edge of a frame
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            armed_q <= 1'b1;
            first_q <= 1'b0;
        end
        else
        begin
            armed_q <= 1'b0;
            first_q <= armed_q;
        end
    end

    // serial output changes on the rising edge
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            sdo_q <= 1'b0;
        else if (armed_q)
            sdo_q <= status_word[CMD_W-1];
        else
            sdo_q <= shift_q[CMD_W-1];
    end

    // input sampled on the falling edge; first edge loads the status word
    always_ff @(negedge sclk)
    begin
        if (!cs_n)
        begin
            if (first_q)
                shift_q <= {status_word[CMD_W-2:0], serial_data_input};
            else
                shift_q <= {shift_q[CMD_W-2:0], serial_data_input};
        end
    end

    // pulse count wraps from 23 back to 16, staying in the 16..23 band
    always_ff @(negedge sclk)
    begin
        if (!cs_n)
        begin
            if (first_q)
                cnt_q <= CNT_ONE;
            else if (cnt_q == CNT_WRAP)
                cnt_q <= CNT_MIN;
            else
                cnt_q <= cnt_q + CNT_ONE;
        end
    end

    assign serial_data_output = sdo_q;

    oss_sync #(
        .W(CTL_W),
        .RST(CTL_RST)
    ) u_sync_ctl (
        .mclk(mclk),
        .nrst(nrst),
        .d({cs_n, chip_activate, direct_drive_six, direct_drive_five,
            armed_q}),
        .q(ctl_s)
    );

    oss_sync #(
        .W(FLT_W),
        .RST(FLT_RST)
    ) u_sync_flt (
        .mclk(mclk),
        .nrst(nrst),
        .d({thermal_limit, open_load, short_fault}),
        .q(flt_s)
    );

    assign cs_s = ctl_s[CTL_CS];
    assign en_s = ctl_s[CTL_EN];
    assign dd5_s = ctl_s[CTL_DD5];
    assign dd6_s = ctl_s[CTL_DD6];
    assign armed_s = ctl_s[CTL_ARMED];

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            cs_prev_q <= 1'b1;
            en_prev_q <= 1'b0;
        end
        else
        begin
            cs_prev_q <= cs_s;
            en_prev_q <= en_s;
        end
    end

    assign cs_rise = cs_s & ~cs_prev_q;
    assign en_rise = en_s & ~en_prev_q;

    // frame saw at least one serial clock edge
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            clocked_q <= 1'b0;
        else if (cs_rise)
            clocked_q <= 1'b0;
        else if (!cs_s && !armed_s)
            clocked_q <= 1'b1;
    end

    // serial clock is stopped at chip select rise, so shift_q is stable
    assign take = cs_rise & clocked_q & (cnt_q == CNT_MIN);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            cmd_q <= CMD_RST;
        else if (!en_s || en_rise)
            cmd_q <= CMD_RST;
        else if (take)
            cmd_q <= shift_q;
    end

    always_comb
    begin
        dd_vec = OUT_OFF;
        dd_vec[OUT5_IDX] = dd5_s;
        dd_vec[OUT6_IDX] = dd6_s;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            out_on_q <= OUT_OFF;
            olc_en_q <= OUT_OFF;
        end
        else if (en_s)
        begin
            out_on_q <= cmd_q[OUT_LSB +: OUT_N] | dd_vec;
            olc_en_q <= cmd_q[OLC_LSB +: OUT_N];
        end
        else
        begin
            out_on_q <= OUT_OFF;
            olc_en_q <= OUT_OFF;
        end
    end

    // off-state open load counts only with its detection current on
    assign fault_vec = flt_s[0 +: OUT_N] | flt_s[2*OUT_N +: OUT_N]
        | (flt_s[OUT_N +: OUT_N] & ~out_on_q & olc_en_q);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            snap_q <= OUT_OFF;
        else if (cs_s)
            snap_q <= fault_vec & {OUT_N{en_s}};
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            sdo_oe_q <= 1'b0;
        else
            sdo_oe_q <= ~cs_s;
    end

    assign serial_data_oe = sdo_oe_q;
    assign out_on = out_on_q;
    assign olc_en = olc_en_q;

    property p_sleep_off;
        @(posedge mclk) disable iff (!nrst)
        !en_s |=> (out_on_q == OUT_OFF) && (olc_en_q == OUT_OFF);
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("outputs active while asleep");
    property p_wake_reset;
        @(posedge mclk) disable iff (!nrst)
        en_rise |=> (cmd_q == CMD_RST) ##1 (out_on_q == dd_vec);
    endproperty
    a_wake_reset: assert property (p_wake_reset)
        else $error("enable rise did not clear command");
    property p_por;
        @(posedge mclk)
        !nrst |=> (cmd_q == CMD_RST) && (out_on_q == OUT_OFF);
    endproperty
    a_por: assert property (p_por)
        else $error("reset left control state set");
    property p_direct_five;
        @(posedge mclk) disable iff (!nrst)
        en_s && dd5_s |=> out_on_q[OUT5_IDX];
    endproperty
    a_direct_five: assert property (p_direct_five)
        else $error("direct drive five not ORed in");
    property p_direct_six;
        @(posedge mclk) disable iff (!nrst)
        en_s && !dd6_s && !cmd_q[OUT6_IDX] |=> !out_on_q[OUT6_IDX];
    endproperty
    a_direct_six: assert property (p_direct_six)
        else $error("output six on without cause");
    property p_out_follow;
        @(posedge mclk) disable iff (!nrst)
        en_s |=> out_on_q[3:0] == $past(cmd_q[3:0])
            && out_on_q[7:6] == $past(cmd_q[7:6]);
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("output does not follow command");
    property p_olc_follow;
        @(posedge mclk) disable iff (!nrst)
        en_s |=> olc_en_q == $past(cmd_q[OLC_LSB +: OUT_N]);
    endproperty
    a_olc_follow: assert property (p_olc_follow)
        else $error("detection current does not follow command");
    property p_take;
        @(posedge mclk) disable iff (!nrst)
        take && en_s && !en_rise |=> cmd_q == $past(shift_q);
    endproperty
    a_take: assert property (p_take)
        else $error("command not transferred at chip select rise");
    property p_bad_count;
        @(posedge mclk) disable iff (!nrst)
        cs_rise && (cnt_q != CNT_MIN) && en_s && !en_rise |=> $stable(cmd_q);
    endproperty
    a_bad_count: assert property (p_bad_count)
        else $error("illegal pulse count changed command");
    property p_frozen;
        @(posedge mclk) disable iff (!nrst)
        !cs_s |=> $stable(snap_q);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("status changed during a frame");
    property p_oe;
        @(posedge mclk) disable iff (!nrst)
        cs_s |=> !sdo_oe_q;
    endproperty
    a_oe: assert property (p_oe)
        else $error("serial output driven while deselected");
    property p_lead_zero;
        @(posedge sclk) disable iff (cs_n)
        armed_q |=> !sdo_q;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("status high bit not zero");
    property p_sample;
        @(negedge sclk) disable iff (cs_n)
        1'b1 |=> shift_q[0] == $past(serial_data_input);
    endproperty
    a_sample: assert property (p_sample)
        else $error("input not sampled on falling edge");
    property p_count_start;
        @(negedge sclk) disable iff (cs_n)
        first_q |=> cnt_q == CNT_ONE;
    endproperty
    a_count_start: assert property (p_count_start)
        else $error("pulse count did not restart");
endmodule : oss_switch_ctrl
`default_nettype wire

// *** testbench/oss_master.sv ***
`default_nettype none
module oss_master (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // serial clock idles low and stands still between frames
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi = 1'b0;
        // a real rising edge so the link flops start known
        #1 cs_n = 1'b1;
    end

    task automatic xfer(input int n, input logic [31:0] tx,
        output logic [31:0] rx);
        rx = '0;
        #7 cs_n = 1'b0;
        #120;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b1;
            #4 sdi = tx[i];
            #12 rx = {rx[30:0], miso};
            sclk = 1'b0;
            #16;
        end
        #60 cs_n = 1'b1;
        // released data line must not keep looking valid
        sdi = ~sdi;
    endtask : xfer
endmodule : oss_master
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic ca = 1'b0;
    logic dd5 = 1'b0;
    logic dd6 = 1'b0;
    logic [OUT_N-1:0] sf = '0;
    logic [OUT_N-1:0] ol = '0;
    logic [OUT_N-1:0] tl = '0;
    wire sclk, cs_n, sdi, sdo, oe, miso;
    wire [OUT_N-1:0] out_on, olc_en;
    logic [CMD_W-1:0] cmd_m, st;
    logic [31:0] tx, rx, mask;
    int n, k, err_count, total_checks;
    integer seed = 32'h451da440;
    int lens[8] = '{16, 24, 32, 16, 0, 15, 17, 23};

    assign miso = oe ? sdo : 1'bz;

    oss_switch_ctrl dut_u (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .serial_data_input(sdi), .serial_data_output(sdo),
        .serial_data_oe(oe), .chip_activate(ca),
        .direct_drive_five(dd5), .direct_drive_six(dd6),
        .short_fault(sf), .open_load(ol), .thermal_limit(tl),
        .out_on(out_on), .olc_en(olc_en)
    );

    oss_master m_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .miso(miso));

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    function automatic logic [OUT_N-1:0] f_out(logic [CMD_W-1:0] c);
        logic [OUT_N-1:0] o;
        o = c[OUT_N-1:0];
        o[OUT5_IDX] |= dd5;
        o[OUT6_IDX] |= dd6;
        return ca ? o : OUT_OFF;
    endfunction : f_out

    function automatic logic [CMD_W-1:0] f_stat(logic [CMD_W-1:0] c);
        logic [OUT_N-1:0] o;
        o = f_out(c);
        o = sf | tl | (ol & ~o & c[CMD_W-1:OLC_LSB]);
        return {STATUS_HI, ca ? o : OUT_OFF};
    endfunction : f_stat

    task automatic tick(int c);
        repeat (c) @(posedge mclk);
    endtask : tick

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    initial
    begin
        #1500000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        tick(3);
        nrst <= 1'b1;
        tick(8);
        `CHK(out_on, OUT_OFF)
        `CHK(olc_en, OUT_OFF)
        cmd_m = CMD_RST;
        for (int g = 0; g < 3; g++)
        begin
            {dd5, dd6} <= 2'($random(seed));
            // direct drive edges kept slow for the pulse rate limit
            tick(12600);
            for (int i = 0; i < 12; i++)
            begin
                ca <= i != 3 && ($random(seed) & 3) != 0;
                sf <= 8'($random(seed) & $random(seed) & $random(seed));
                ol <= 8'($random(seed));
                tl <= 8'($random(seed) & $random(seed) & $random(seed));
                tick(10);
                if (!ca)
                    cmd_m = CMD_RST;
                `CHK(out_on, f_out(cmd_m))
                `CHK(olc_en, ca ? cmd_m[CMD_W-1:OLC_LSB] : OUT_OFF)
                n = lens[$random(seed) & 7];
                tx = $random(seed);
                tx[OUT5_IDX] &= ~dd5;
                tx[OUT6_IDX] &= ~dd6;
                st = f_stat(cmd_m);
                m_u.xfer(n, tx, rx);
                if (n >= 16)
                begin
                    mask = (32'h1 << (n - 16)) - 32'h1;
                    `CHK(rx[n-1 -: 16], st)
                    `CHK(rx & mask, (tx >> 16) & mask)
                end
                if (ca && (n == 16 || n == 24 || n == 32))
                    cmd_m = tx[CMD_W-1:0];
                for (k = 0; k < 20 && oe !== 1'b0; k++)
                    tick(1);
                if (k == 20)
                begin
                    err_count++;
                    end_of_test();
                end
                // looked at once the deselect has settled, not in its step
                `CHK(sdo, 1'b0)
            end
        end
        tick(5);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
